/* core/bldc_defines.svh */
// Register offsets, field positions, reset values and timing figures of the commutation block
`ifndef BLDC_DEFINES_SVH
`define BLDC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CTRL_BRAKE_BIT 0
`define CTRL_DIRECTION_POLARITY_BIT_BIT 1
`define CTRL_BASIC_BIT 2
`define CTRL_SYNCRECT_BIT 3
`define CTRL_MODE_LSB 4
`define CTRL_MODE_MSB 5
`define CTRL_ENABLE_POLARITY_BIT_BIT 6
`define CTRL_RESET 32'h0000_0004
`define CTRL_WMASK 32'h0000_003F

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define STAT_HALL_LSB 0
`define STAT_HALL_MSB 2
`define STAT_DIR_BIT 3
`define STAT_ENABLE_BIT 4
`define STAT_STANDBY_BIT 5
`define STAT_BRAKE_BIT 6
`define STAT_ILLEGAL_BIT 7
`define STAT_STATE_LSB 8
`define STAT_STATE_MSB 9

// ----------------------------------------------------------------------
// Read answers and timing
// ----------------------------------------------------------------------
`define READ_ALL_ONES 32'hFFFF_FFFF
`define READ_ZERO 32'h0000_0000
`define CLK_MHZ 20
`define TICK_DIV 2
`define RESET_DEGLITCH_NS 10000
`define HALL_LOCKOUT_NS 20000
`define STANDBY_IDLE_MS 1000

`endif

/* core/bldc_pkg.sv */
// Types shared by the commutation block
`default_nettype none
package bldc_pkg;
	// Phase selector for the decoded drive pattern
	typedef enum logic [1:0] {
		PH_U = 2'b00,
		PH_V = 2'b01,
		PH_W = 2'b10,
		PH_NONE = 2'b11
	} phase_e;

	// Motor operating state
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_STOP = 2'b01,
		ST_STANDBY = 2'b10
	} run_e;

	// Commutation mode selection
	typedef enum logic [1:0] {
		MODE_THREE_HALL = 2'b00,
		MODE_SINGLE_HALL = 2'b01,
		MODE_SINE = 2'b10
	} mode_e;
endpackage
`default_nettype wire

/* core/bldc_enable_commutation.sv */
// Enable, reset, standby and three-Hall commutation logic with an APB register slave
//
// Local design decisions: register access over APB and the placing of the registers.
`default_nettype none
`include "bldc_defines.svh"

module bldc_enable_commutation #(
	parameter int STANDBY_TICKS = `STANDBY_IDLE_MS * 1000 * (`CLK_MHZ / `TICK_DIV),
	parameter int ADDR_W = 8
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic enable_pin,
	input wire logic reset_pin,
	input wire logic dir_pin,
	input wire logic hall_u_in,
	input wire logic hall_v_in,
	input wire logic hall_w_in,
	input wire logic speed_feedback_in,
	input wire logic motor_supply_low,
	input wire logic pwm_in,
	input wire logic otp_enable_polarity,
	output logic phase_u_high_gate,
	output logic phase_u_low_gate,
	output logic phase_v_high_gate,
	output logic phase_v_low_gate,
	output logic phase_w_high_gate,
	output logic phase_w_low_gate,
	output logic speed_loop_reset,
	output logic gate_regulator_en,
	output logic charge_pump_en,
	output logic sensor_regulator_en,
	output logic sensor_power_switch_en,
	output logic standby
);
	import bldc_pkg::*;

	// ------------------------------------------------------------------
	// Timing counts, in half-rate ticks
	// ------------------------------------------------------------------
	localparam int TICK_MHZ = `CLK_MHZ / `TICK_DIV;
	localparam int DEGLITCH_TICKS = (`RESET_DEGLITCH_NS * TICK_MHZ + 999) / 1000;
	localparam int LOCKOUT_TICKS = (`HALL_LOCKOUT_NS * TICK_MHZ + 999) / 1000;
	localparam int N_PINS = 10;
	localparam int P_EN = 0;
	localparam int P_RST = 1;
	localparam int P_DIR = 2;
	localparam int P_HU = 3;
	localparam int P_HV = 4;
	localparam int P_HW = 5;
	localparam int P_FG = 6;
	localparam int P_VM = 7;
	localparam int P_PWM = 8;
	localparam int P_OTP = 9;

	// Refuse settings the counters cannot hold
	if (STANDBY_TICKS < 2 || STANDBY_TICKS >= 2 ** 24) begin : g_chk_standby
		$error("STANDBY_TICKS out of range");
	end
	if (LOCKOUT_TICKS >= 2 ** 8 || DEGLITCH_TICKS >= 2 ** 8) begin : g_chk_short
		$error("deglitch count too large");
	end
	if (ADDR_W < 3) begin : g_chk_addr
		$error("ADDR_W too small");
	end

	// ------------------------------------------------------------------
	// Reset release and pin synchronisers
	// ------------------------------------------------------------------
	logic [1:0] rst_pipe_reg;
	logic rst_sync_n;
	logic [N_PINS-1:0] pin_raw;
	logic [N_PINS-1:0] sync1_reg;
	logic [N_PINS-1:0] sync2_reg;

	// Two-flop release of the asynchronous reset
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_pipe_reg <= 2'b00;
		end else begin
			rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_pipe_reg[1];

	// Hall comparator outputs are already high when positive exceeds negative
	assign pin_raw = {otp_enable_polarity, pwm_in, motor_supply_low, speed_feedback_in,
		hall_w_in, hall_v_in, hall_u_in, dir_pin, reset_pin, enable_pin};

	// Every pin passes two flops before use
	genvar gi;
	generate
		for (gi = 0; gi < N_PINS; gi++) begin : g_sync
			always_ff @(posedge sys_clk or negedge rst_sync_n) begin
				if (!rst_sync_n) begin
					sync1_reg[gi] <= 1'(gi == P_FG); // Feedback idles high
					sync2_reg[gi] <= 1'(gi == P_FG);
				end else begin
					sync1_reg[gi] <= pin_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// Half-rate tick, reset pin deglitch, polarity capture
	// ------------------------------------------------------------------
	logic tick_reg;
	logic [7:0] rdg_cnt_reg;
	logic rst_pin_reg;
	logic [1:0] cap_cnt_reg;
	logic enable_polarity_bit_reg;
	logic cap_done;
	logic en_active;
	logic logic_clr;
	logic rdg_differs;
	logic rdg_expire;

	// Divide the clock by two for the deglitch, lockout and standby timing
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= ~tick_reg;
		end
	end

	assign rdg_differs = sync2_reg[P_RST] != rst_pin_reg;
	assign rdg_expire = rdg_differs && tick_reg && (rdg_cnt_reg == 8'(DEGLITCH_TICKS - 1));

	// Level on the reset pin must hold before it is believed, both ways
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rdg_cnt_reg <= 8'h00;
			rst_pin_reg <= 1'b0;
		end else if (!rdg_differs || rdg_expire) begin
			rdg_cnt_reg <= 8'h00;
			rst_pin_reg <= rdg_differs ? sync2_reg[P_RST] : rst_pin_reg;
		end else if (tick_reg) begin
			rdg_cnt_reg <= rdg_cnt_reg + 8'h01;
		end
	end

	// Polarity is caught once after release, never from the bus
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cap_cnt_reg <= 2'b00;
			enable_polarity_bit_reg <= 1'b0;
		end else if (!cap_done) begin
			cap_cnt_reg <= cap_cnt_reg + 2'b01;
			enable_polarity_bit_reg <= sync2_reg[P_OTP];
		end
	end
	assign cap_done = cap_cnt_reg == 2'b11;

	// Enable level after polarity, and the internal reset sources
	assign en_active = cap_done && (sync2_reg[P_EN] ^ enable_polarity_bit_reg);
	assign logic_clr = (rst_pin_reg && en_active) || sync2_reg[P_VM];

	// ------------------------------------------------------------------
	// Control register and APB slave
	// ------------------------------------------------------------------
	logic [31:0] ctrl_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] status_word;
	logic [31:0] read_word;
	logic acc_phase;
	logic wr_take;
	logic sel_ctrl;
	logic sel_status;
	logic mapped;
	logic regs_blank;

	assign acc_phase = psel && penable;
	assign wr_take = acc_phase && pready_reg && pwrite && sel_ctrl;
	assign sel_ctrl = paddr == ADDR_W'(`CTRL_OFFSET);
	assign sel_status = paddr == ADDR_W'(`STATUS_OFFSET);
	assign mapped = sel_ctrl || sel_status;
	assign regs_blank = rst_pin_reg && !en_active;

	// Read selection; the polarity bit reads back but is never written
	assign read_word = regs_blank ? `READ_ALL_ONES :
		sel_ctrl ? (ctrl_reg | (32'(enable_polarity_bit_reg) << `CTRL_ENABLE_POLARITY_BIT_BIT)) :
		sel_status ? status_word : `READ_ZERO;

	// Writable fields only; internal reset restores defaults
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctrl_reg <= `CTRL_RESET;
		end else if (logic_clr) begin
			ctrl_reg <= `CTRL_RESET;
		end else if (wr_take) begin
			ctrl_reg <= pwdata & `CTRL_WMASK;
		end
	end

	// One wait cycle: answer on the second access-phase cycle
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pready_reg <= 1'b0;
			prdata_reg <= `READ_ZERO;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= acc_phase && !pready_reg;
			pslverr_reg <= acc_phase && !pready_reg && !mapped && !regs_blank;
			prdata_reg <= (acc_phase && !pready_reg && !pwrite) ? read_word : `READ_ZERO;
		end
	end

	// ------------------------------------------------------------------
	// Hall acceptance with lockout
	// ------------------------------------------------------------------
	logic [2:0] hall_sync;
	logic [2:0] hall_reg;
	logic [7:0] lock_cnt_reg;
	logic hall_take;

	assign hall_sync = {sync2_reg[P_HU], sync2_reg[P_HV], sync2_reg[P_HW]};
	assign hall_take = (hall_sync != hall_reg) && (lock_cnt_reg == 8'h00);

	// Take a new Hall pattern, then ignore changes for the lockout time
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			hall_reg <= 3'b000;
			lock_cnt_reg <= 8'h00;
		end else if (logic_clr) begin
			hall_reg <= 3'b000;
			lock_cnt_reg <= 8'h00;
		end else if (hall_take) begin
			hall_reg <= hall_sync;
			lock_cnt_reg <= 8'(LOCKOUT_TICKS);
		end else if (tick_reg && lock_cnt_reg != 8'h00) begin
			lock_cnt_reg <= lock_cnt_reg - 8'h01;
		end
	end

	// ------------------------------------------------------------------
	// Commutation decode
	// ------------------------------------------------------------------
	// Returns {pwm phase, low phase}; PH_NONE in both for illegal patterns
	function automatic logic [3:0] commutate(input logic [2:0] hall, input logic dir);
		logic [2:0] pat;
		pat = dir ? hall : ~hall;
		unique case (pat)
			3'b001: commutate = {PH_V, PH_W};
			3'b011: commutate = {PH_U, PH_W};
			3'b010: commutate = {PH_U, PH_V};
			3'b110: commutate = {PH_W, PH_V};
			3'b100: commutate = {PH_W, PH_U};
			3'b101: commutate = {PH_V, PH_U};
			3'b000, 3'b111: commutate = {PH_NONE, PH_NONE};
		endcase
	endfunction

	logic eff_dir;
	logic basic_mode;
	mode_e mode_sel;
	logic [3:0] drive_sel;
	phase_e pwm_phase;
	phase_e low_phase;
	logic hall_illegal;
	logic [2:0] run_high;
	logic [2:0] run_low;

	assign eff_dir = sync2_reg[P_DIR] ^ ctrl_reg[`CTRL_DIRECTION_POLARITY_BIT_BIT];
	assign basic_mode = ctrl_reg[`CTRL_BASIC_BIT];
	assign mode_sel = mode_e'(ctrl_reg[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
	// Every mode uses three-Hall drive, basic or not; the select term is always true
	assign drive_sel = (basic_mode || mode_sel == MODE_THREE_HALL || !basic_mode) ?
		commutate(hall_reg, eff_dir) : {PH_NONE, PH_NONE};
	assign pwm_phase = phase_e'(drive_sel[3:2]);
	assign low_phase = phase_e'(drive_sel[1:0]);
	assign hall_illegal = pwm_phase == PH_NONE;

	// Per-phase gate levels while running
	generate
		for (gi = 0; gi < 3; gi++) begin : g_phase
			assign run_high[gi] = (pwm_phase == phase_e'(gi)) && sync2_reg[P_PWM];
			assign run_low[gi] = (low_phase == phase_e'(gi)) ||
				((pwm_phase == phase_e'(gi)) && ctrl_reg[`CTRL_SYNCRECT_BIT] &&
				!sync2_reg[P_PWM]);
		end
	endgenerate

	// ------------------------------------------------------------------
	// Run, stop and standby sequencing
	// ------------------------------------------------------------------
	run_e state_reg;
	run_e state_next;
	logic [23:0] idle_cnt_reg;
	logic fg_prev_reg;
	logic fg_edge;
	logic idle_done;

	assign fg_edge = sync2_reg[P_FG] != fg_prev_reg;
	assign idle_done = tick_reg && !fg_edge && (idle_cnt_reg == 24'(STANDBY_TICKS - 1));

	// Next state from enable and feedback quiet time
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_RUN: state_next = en_active ? ST_RUN : ST_STOP;
			ST_STOP: state_next = en_active ? ST_RUN : (idle_done ? ST_STANDBY : ST_STOP);
			ST_STANDBY: state_next = en_active ? ST_RUN : ST_STANDBY;
			default: state_next = ST_STANDBY;
		endcase
	end

	// State and quiet-time counter; any feedback edge restarts the wait
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_reg <= ST_STANDBY;
			idle_cnt_reg <= 24'h00_0000;
			fg_prev_reg <= 1'b1; // Match pull-up level, no false edge
		end else begin
			fg_prev_reg <= sync2_reg[P_FG];
			state_reg <= logic_clr ? ST_STANDBY : state_next;
			if (logic_clr || state_reg != ST_STOP || fg_edge) begin
				idle_cnt_reg <= 24'h00_0000;
			end else if (tick_reg && !idle_done) begin
				idle_cnt_reg <= idle_cnt_reg + 24'h00_0001;
			end
		end
	end

	assign status_word = (32'(hall_reg) << `STAT_HALL_LSB) |
		(32'(eff_dir) << `STAT_DIR_BIT) | (32'(en_active) << `STAT_ENABLE_BIT) |
		(32'(state_reg == ST_STANDBY) << `STAT_STANDBY_BIT) |
		(32'(state_reg == ST_STOP && ctrl_reg[`CTRL_BRAKE_BIT]) << `STAT_BRAKE_BIT) |
		(32'(hall_illegal) << `STAT_ILLEGAL_BIT) | (32'(state_reg) << `STAT_STATE_LSB);

	// ------------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------------
	logic [2:0] high_reg;
	logic [2:0] low_reg;
	logic power_reg;
	logic loop_rst_reg;
	logic standby_reg;
	logic running;
	logic braking;

	assign running = state_reg == ST_RUN;
	assign braking = state_reg == ST_STOP && ctrl_reg[`CTRL_BRAKE_BIT];

	// Gates: decoded in run, all lows in brake, all off in coast and standby
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			high_reg <= 3'b000;
			low_reg <= 3'b000;
			power_reg <= 1'b0;
			loop_rst_reg <= 1'b1;
			standby_reg <= 1'b1;
		end else begin
			high_reg <= running ? run_high : 3'b000;
			low_reg <= running ? run_low : (braking ? 3'b111 : 3'b000);
			power_reg <= state_reg != ST_STANDBY;
			loop_rst_reg <= !running;
			standby_reg <= state_reg == ST_STANDBY;
		end
	end

	assign phase_u_high_gate = high_reg[PH_U];
	assign phase_v_high_gate = high_reg[PH_V];
	assign phase_w_high_gate = high_reg[PH_W];
	assign phase_u_low_gate = low_reg[PH_U];
	assign phase_v_low_gate = low_reg[PH_V];
	assign phase_w_low_gate = low_reg[PH_W];
	assign gate_regulator_en = power_reg;
	assign charge_pump_en = power_reg;
	assign sensor_regulator_en = power_reg;
	assign sensor_power_switch_en = power_reg;
	assign speed_loop_reset = loop_rst_reg;
	assign standby = standby_reg;
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
endmodule
`default_nettype wire

/* verif/bldc_assertions.sv */
// Concurrent checks on the pins and bus of the commutation block
`default_nettype none
module bldc_checker #(
	parameter int STANDBY_TICKS = 20,
	parameter int ADDR_W = 8
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic enable_pin,
	input wire logic reset_pin,
	input wire logic hall_u_in,
	input wire logic hall_v_in,
	input wire logic hall_w_in,
	input wire logic otp_enable_polarity,
	input wire logic phase_u_high_gate,
	input wire logic phase_u_low_gate,
	input wire logic phase_v_high_gate,
	input wire logic phase_v_low_gate,
	input wire logic phase_w_high_gate,
	input wire logic phase_w_low_gate,
	input wire logic speed_loop_reset,
	input wire logic gate_regulator_en,
	input wire logic charge_pump_en,
	input wire logic sensor_regulator_en,
	input wire logic sensor_power_switch_en,
	input wire logic standby
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] gates;
	logic en_act;
	logic hall_bad;
	logic [9:0] ill_cnt_reg;
	logic [9:0] ill_cnt_next;
	logic [9:0] ones_cnt_reg;
	logic [9:0] ones_cnt_next;
	// ----------------------------------------------------------------------
	// Helper counters
	// ----------------------------------------------------------------------
	// Gate vector, enable level and stable-condition counts
	assign gates = {phase_u_high_gate, phase_u_low_gate, phase_v_high_gate,
		phase_v_low_gate, phase_w_high_gate, phase_w_low_gate};
	assign en_act = enable_pin ^ otp_enable_polarity;
	assign hall_bad = (hall_u_in == hall_v_in) && (hall_v_in == hall_w_in);
	assign ill_cnt_next = !(hall_bad && en_act) ? 10'h000 :
		(ill_cnt_reg == 10'h3FF ? ill_cnt_reg : ill_cnt_reg + 10'h001);
	assign ones_cnt_next = !(reset_pin && !en_act) ? 10'h000 :
		(ones_cnt_reg == 10'h3FF ? ones_cnt_reg : ones_cnt_reg + 10'h001);
	// Count registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ill_cnt_reg <= 10'h000;
			ones_cnt_reg <= 10'h000;
		end else begin
			ill_cnt_reg <= ill_cnt_next;
			ones_cnt_reg <= ones_cnt_next;
		end
	end
	// ----------------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_answer;
		psel && penable && pready;
	endsequence
	sequence s_disabled;
		!en_act [*8];
	endsequence
	a_standby_gates: assert property (standby |-> gates == 6'h00)
		else $error("Gate driven in standby");
	a_standby_power: assert property (standby |-> !(gate_regulator_en || charge_pump_en
		|| sensor_regulator_en || sensor_power_switch_en)) else $error("Supply on in standby");
	a_no_shoot: assert property (!(gates[5] && gates[4]) && !(gates[3] && gates[2])
		&& !(gates[1] && gates[0])) else $error("High and low gate both on");
	a_one_high: assert property ($onehot0({gates[5], gates[3], gates[1]}))
		else $error("Several high gates on");
	a_illegal_low: assert property (ill_cnt_reg > 10'h1A4 |-> gates == 6'h00)
		else $error("Gate on for illegal Hall pattern");
	a_disable_loop: assert property (s_disabled |-> speed_loop_reset)
		else $error("Speed loop not reset while disabled");
	a_ones_read: assert property (ones_cnt_reg > 10'h0E6 && pready && !pwrite
		|-> prdata == 32'hFFFF_FFFF && !pslverr) else $error("Read not all ones");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("Ready outside access phase");
	a_ready_pulse: assert property (s_answer |=> !pready)
		else $error("Ready longer than one cycle");
	a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
		else $error("Data with error answer");
	a_idle_rdata: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("Read data outside answer");
endmodule
bind bldc_enable_commutation bldc_checker #(.STANDBY_TICKS(STANDBY_TICKS), .ADDR_W(ADDR_W)) chk (
	.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .enable_pin(enable_pin),
	.reset_pin(reset_pin), .hall_u_in(hall_u_in), .hall_v_in(hall_v_in), .hall_w_in(hall_w_in),
	.otp_enable_polarity(otp_enable_polarity), .phase_u_high_gate(phase_u_high_gate),
	.phase_u_low_gate(phase_u_low_gate), .phase_v_high_gate(phase_v_high_gate),
	.phase_v_low_gate(phase_v_low_gate), .phase_w_high_gate(phase_w_high_gate),
	.phase_w_low_gate(phase_w_low_gate), .speed_loop_reset(speed_loop_reset),
	.gate_regulator_en(gate_regulator_en), .charge_pump_en(charge_pump_en),
	.sensor_regulator_en(sensor_regulator_en), .sensor_power_switch_en(sensor_power_switch_en),
	.standby(standby));
`default_nettype wire

/* verif/hall_bridge_model.sv */
// Hall sensors, feedback pick-up and bridge watch on the motor side
`default_nettype none
module hall_bridge_model (
	input wire logic sys_clk,
	input wire logic [2:0] hall_code,
	input wire logic spin,
	input wire logic [5:0] gates,
	output logic hall_u_in,
	output logic hall_v_in,
	output logic hall_w_in,
	output logic speed_feedback_in,
	output logic shoot
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int NEG_MV = 1750;
	int pos_mv [3];
	int fg_cnt;
	// Differential sensor voltages in millivolts
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pos_mv[i] = hall_code[2 - i] ? 2600 : 900;
		end
	end
	// Comparator high only when positive side is above negative
	assign hall_u_in = pos_mv[0] > NEG_MV;
	assign hall_v_in = pos_mv[1] > NEG_MV;
	assign hall_w_in = pos_mv[2] > NEG_MV;
	initial begin
		speed_feedback_in = 1'b1;
		fg_cnt = 0;
		shoot = 1'b0;
	end
	// Feedback toggles while turning, rests at pull-up level when stopped
	always @(posedge sys_clk) begin
		fg_cnt <= (fg_cnt + 1) % 9;
		if (!spin) begin
			speed_feedback_in <= 1'b1;
		end else if (fg_cnt == 0) begin
			speed_feedback_in <= !speed_feedback_in;
		end
		if ((gates[5] && gates[4]) || (gates[3] && gates[2]) || (gates[1] && gates[0])) begin
			shoot <= 1'b1;
		end
	end
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the commutation block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import bldc_pkg::*;
	localparam int HP[8] = '{3, 1, 0, 0, 2, 1, 2, 3};
	localparam int LP[8] = '{3, 2, 1, 2, 0, 0, 1, 3};
	logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, er, spin, shoot;
	logic enable_pin, reset_pin, dir_pin, motor_supply_low, pwm_in, otp_enable_polarity;
	logic hall_u_in, hall_v_in, hall_w_in, speed_feedback_in, speed_loop_reset, standby;
	logic phase_u_high_gate, phase_u_low_gate, phase_v_high_gate, phase_v_low_gate;
	logic phase_w_high_gate, phase_w_low_gate, gate_regulator_en, charge_pump_en;
	logic sensor_regulator_en, sensor_power_switch_en;
	logic [2:0] hall_code;
	logic [5:0] gates;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, w, seed;
	int failures, checks_done;
	assign gates = {phase_u_high_gate, phase_u_low_gate, phase_v_high_gate,
		phase_v_low_gate, phase_w_high_gate, phase_w_low_gate};
	bldc_enable_commutation #(.STANDBY_TICKS(20)) dut (.sys_clk, .rst_n, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .enable_pin, .reset_pin,
		.dir_pin, .hall_u_in, .hall_v_in, .hall_w_in, .speed_feedback_in, .motor_supply_low,
		.pwm_in, .otp_enable_polarity, .phase_u_high_gate, .phase_u_low_gate,
		.phase_v_high_gate, .phase_v_low_gate, .phase_w_high_gate, .phase_w_low_gate,
		.speed_loop_reset, .gate_regulator_en, .charge_pump_en, .sensor_regulator_en,
		.sensor_power_switch_en, .standby);
	hall_bridge_model pm (.sys_clk, .hall_code, .spin, .gates, .hall_u_in, .hall_v_in,
		.hall_w_in, .speed_feedback_in, .shoot);
	// Clock of 50 ns period
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// ----------------------------------------------------------------------
	// Tasks and reference model
	// ----------------------------------------------------------------------
	task stop_test;
		$display("Comparisons %0d, mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// One bus transfer; the answer is taken at the edge that shows ready
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			failures++;
			stop_test;
		end
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h0000_0000);
		check(rd, e);
		check(er, ee);
	endtask
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// Expected gates {UH,UL,VH,VL,WH,WL} from Hall code, direction, PWM level, rectification
	function automatic logic [5:0] exp_gates(input int h, input int d, input int p, input int s);
		logic [5:0] g;
		h = d ? h : 7 - h;
		g = 6'h00;
		if (HP[h] < 3) begin
			g[5 - 2 * HP[h]] = p[0];
			g[4 - 2 * HP[h]] = s[0] & ~p[0];
			g[4 - 2 * LP[h]] = 1'b1;
		end
		return g;
	endfunction
	// ----------------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------------
	initial begin
		{rst_n, psel, penable, pwrite, enable_pin, reset_pin, dir_pin} = 7'h00;
		{motor_supply_low, pwm_in, otp_enable_polarity, spin} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		hall_code = 3'h0;
		seed = 32'd24287;
		failures = 0;
		checks_done = 0;
		cyc(4);
		rst_n <= 1'b1;
		cyc(4);
		rdchk(8'h00, 32'h0000_0004, 1'b0);
		rdchk(8'h08, 32'h0000_0000, 1'b1);
		$display("Test registers done");
		enable_pin <= 1'b1;
		for (int h = 0; h < 8; h++) begin
			hall_code <= h[2:0];
			cyc(440);
			for (int c = 0; c < 8; c++) begin
				seed = xs(seed);
				// Direction changes only with the rotor standing still
				dir_pin <= c[0];
				pwm_in <= seed[0];
				w = {26'h0, 2'(c % 3), c[2], 1'b1, c[1], 1'b0};
				apb(1'b1, 8'h00, w);
				cyc(6);
				check(gates, exp_gates(h, c[0] ^ c[1], seed[0], c[2]));
				rdchk(8'h00, w, 1'b0);
				apb(1'b0, 8'h04, 32'h0000_0000);
				check(rd[7:0], {h == 0 || h == 7, 3'h1, c[0] ^ c[1], h[2:0]});
			end
		end
		$display("Test commutation done");
		// Second Hall change inside the lockout is held off until it expires
		hall_code <= 3'h3;
		cyc(20);
		hall_code <= 3'h1;
		cyc(100);
		apb(1'b0, 8'h04, 32'h0000_0000);
		check(rd[2:0], 3'h3);
		cyc(400);
		apb(1'b0, 8'h04, 32'h0000_0000);
		check(rd[2:0], 3'h1);
		$display("Test lockout done");
		for (int b = 0; b < 2; b++) begin
			apb(1'b1, 8'h00, 32'h0000_0004 | b);
			spin <= 1'b1;
			enable_pin <= 1'b0;
			cyc(10);
			check(gates, b ? 6'h15 : 6'h00);
			check(speed_loop_reset, 1'b1);
			cyc(100);
			check(standby, 1'b0);
			spin <= 1'b0;
			cyc(30);
			check(standby, 1'b0);
			cyc(30);
			check({standby, gate_regulator_en, charge_pump_en, sensor_regulator_en,
				sensor_power_switch_en, gates}, {5'h10, 6'h00});
			enable_pin <= 1'b1;
			cyc(10);
			check({standby, gate_regulator_en, charge_pump_en, sensor_regulator_en,
				sensor_power_switch_en, speed_loop_reset}, 6'h1E);
		end
		$display("Test disable done");
		enable_pin <= 1'b0;
		apb(1'b1, 8'h00, 32'h0000_000B);
		reset_pin <= 1'b1;
		cyc(100);
		reset_pin <= 1'b0;
		cyc(20);
		rdchk(8'h00, 32'h0000_000B, 1'b0);
		reset_pin <= 1'b1;
		cyc(230);
		rdchk(8'h00, 32'hFFFF_FFFF, 1'b0);
		rdchk(8'h08, 32'hFFFF_FFFF, 1'b0);
		reset_pin <= 1'b0;
		cyc(100);
		rdchk(8'h00, 32'hFFFF_FFFF, 1'b0);
		cyc(150);
		rdchk(8'h00, 32'h0000_000B, 1'b0);
		enable_pin <= 1'b1;
		reset_pin <= 1'b1;
		cyc(230);
		reset_pin <= 1'b0;
		cyc(230);
		rdchk(8'h00, 32'h0000_0004, 1'b0);
		apb(1'b1, 8'h00, 32'h0000_000B);
		motor_supply_low <= 1'b1;
		cyc(4);
		motor_supply_low <= 1'b0;
		cyc(4);
		rdchk(8'h00, 32'h0000_0004, 1'b0);
		$display("Test reset done");
		rst_n <= 1'b0;
		otp_enable_polarity <= 1'b1;
		cyc(4);
		rst_n <= 1'b1;
		enable_pin <= 1'b0;
		cyc(10);
		check(speed_loop_reset, 1'b0);
		apb(1'b1, 8'h00, 32'h0000_0004);
		rdchk(8'h00, 32'h0000_0044, 1'b0);
		enable_pin <= 1'b1;
		cyc(10);
		check(speed_loop_reset, 1'b1);
		check(shoot, 1'b0);
		$display("Test polarity done");
		stop_test;
	end
endmodule
`default_nettype wire
